/* hw/lbs_device.sv */
// bridge end: local bus slave termination, reset and interrupt pins
//
// How it works
// - hold transfer in progress during own mastering
// - master selects pci window for forwarding
// - master selects register window for registers
// - normal slave cycles end with acknowledge
// - drive acknowledge negated before releasing
// - retry is acknowledge plus error together
// - image choice picks slave image, address timing
// - everything runs on the one local clock
// - pull interrupt line on internal event
// - incoming interrupt maps onto pci inta
// - local reset spares pci config state
// - reset out on pci reset or soft reset
// - capture address on transfer start edge
// - chip selects accepted up to three waits
// - register offset from low twelve bits
`timescale 1ns/1ps
`include "lbs_cfg.svh"
module lbs_device
  import lbs_pkg::*;
#(
  parameter int CS_WAIT_MAX = `LBS_CS_WAIT_MAX
)
(
  input wire logic clk_sys,
  input wire logic reset,
  lbs_link_if.device_end link,
  input wire logic master_active,
  input wire logic pci_reset_in,
  input wire logic soft_reset_bit,
  input wire logic irq_event,
  input wire logic irq_in_enable,
  input wire logic resp_valid,
  input wire lbs_term_t resp_kind,
  output logic req_valid,
  output lbs_target_t req_target,
  output logic [31:0] req_addr,
  output logic [`LBS_REG_OFS_BITS-1:0] req_reg_offset,
  output logic req_rw,
  output logic req_image,
  output logic local_side_reset,
  output logic pci_inta_n
);
  typedef enum logic [1:0] {LBS_IDLE, LBS_SELECT, LBS_WAIT, LBS_NEGATE} lbs_state_t;
  lbs_state_t state_reg, state_next;
  logic [1:0] wait_reg, wait_next;
  logic [31:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic img_reg, img_next;
  logic tgt_reg, tgt_next;
  logic req_reg, req_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic drive_reg, drive_next;
  logic tip_reg, tip_next;
  logic sel_pci, sel_reg, any_sel;
  // ----------------------------------------------------------------
  // termination coding
  // ----------------------------------------------------------------
  // {acknowledge, error} as asserted levels; an illegal kind ends as an error
  // so a corrupt response can never pass for a clean completion
  function automatic logic [1:0] term_pins(input lbs_term_t kind);
    unique case (kind)
      LBS_TERM_ACK: term_pins = 2'h2;
      LBS_TERM_RETRY: term_pins = 2'h3;
      LBS_TERM_ERROR: term_pins = 2'h1;
      default: term_pins = 2'h1;
    endcase
  endfunction : term_pins
  // ----------------------------------------------------------------
  // resets
  // ----------------------------------------------------------------
  // local reset only clears the local side; pci config lives elsewhere
  assign local_side_reset = reset | ~link.local_reset_in_n;
  assign link.reset_out_oe = pci_reset_in | soft_reset_bit;
  // ----------------------------------------------------------------
  // slave cycle sequencing
  // ----------------------------------------------------------------
  assign sel_pci = ~link.pci_window_select_n;
  assign sel_reg = ~link.register_window_select_n;
  assign any_sel = sel_pci | sel_reg;
  always_comb
  begin
    state_next = state_reg;
    wait_next = wait_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    img_next = img_reg;
    tgt_next = tgt_reg;
    req_next = 1'b0;
    ack_next = 1'b0;
    err_next = 1'b0;
    drive_next = drive_reg;
    tip_next = master_active;
    unique case (state_reg)
      LBS_IDLE:
      begin
        drive_next = 1'b0;
        // a start seen in any other state is ignored; the master waits for idle
        if (~link.transfer_start_n)
        begin
          addr_next = link.addr;
          rw_next = link.rw;
          img_next = link.image_choice;
          wait_next = 2'h0;
          if (any_sel)
          begin
            tgt_next = sel_reg;
            req_next = 1'b1;
            state_next = LBS_WAIT;
          end
          else
            state_next = LBS_SELECT;
        end
      end
      LBS_SELECT:
      begin
        // a select on the third wait edge is still taken; after that the
        // cycle belongs to someone else and the pins stay released
        if (any_sel)
        begin
          tgt_next = sel_reg;
          req_next = 1'b1;
          state_next = LBS_WAIT;
        end
        else if (wait_reg == 2'(CS_WAIT_MAX - 1))
          state_next = LBS_IDLE;
        else
          wait_next = wait_reg + 2'h1;
      end
      LBS_WAIT:
      begin
        if (resp_valid)
        begin
          drive_next = 1'b1;
          {ack_next, err_next} = term_pins(resp_kind);
          state_next = LBS_NEGATE;
        end
      end
      LBS_NEGATE:
      begin
        // one cycle of driven negation, then release next cycle
        state_next = LBS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (local_side_reset)
    begin
      state_reg <= LBS_IDLE;
      wait_reg <= 2'h0;
      addr_reg <= 32'h0;
      rw_reg <= 1'b0;
      img_reg <= 1'b0;
      tgt_reg <= 1'b0;
      req_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      drive_reg <= 1'b0;
      tip_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      img_reg <= img_next;
      tgt_reg <= tgt_next;
      req_reg <= req_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      drive_reg <= drive_next;
      tip_reg <= tip_next;
    end
  end
  // ----------------------------------------------------------------
  // pin and request outputs
  // ----------------------------------------------------------------
  assign link.transfer_ack_n_o = ~ack_reg;
  assign link.transfer_ack_n_oe = drive_reg;
  assign link.transfer_error_n_o = ~err_reg;
  assign link.transfer_error_n_oe = drive_reg;
  assign link.transfer_in_progress_n_o = ~tip_reg;
  assign link.transfer_in_progress_n_oe = tip_reg;
  assign req_valid = req_reg;
  assign req_target = lbs_target_t'(tgt_reg);
  assign req_addr = addr_reg;
  assign req_reg_offset = addr_reg[`LBS_REG_OFS_BITS-1:0];
  assign req_rw = rw_reg;
  assign req_image = img_reg;
  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  lbs_irq_route u_irq
  (
    .clk_sys(clk_sys),
    .reset(local_side_reset),
    .irq_event(irq_event),
    .irq_in_enable(irq_in_enable),
    .local_irq_n(link.local_irq_n),
    .irq_pin_oe(link.irq_dev_oe),
    .pci_inta_n(pci_inta_n)
  );
endmodule : lbs_device

/* shared/lbs_cfg.svh */
// timing counts and field layout for the local bus slave link
`ifndef LBS_CFG_SVH
`define LBS_CFG_SVH
`define LBS_CS_WAIT_MAX 3
`define LBS_REG_OFS_BITS 12
`define LBS_ADDR_BITS 32
`define LBS_RESP_LAT 1
`define LBS_CLK_MAX_MHZ 40
`define LBS_CLK_MHZ 100
`endif

/* shared/lbs_pkg.sv */
// types shared by both ends of the local bus slave link
package lbs_pkg;
  typedef enum logic [1:0] {LBS_TERM_ACK, LBS_TERM_RETRY, LBS_TERM_ERROR} lbs_term_t;
  typedef enum logic [0:0] {LBS_TGT_PCI, LBS_TGT_REG} lbs_target_t;
endpackage : lbs_pkg

/* shared/lbs_link_if.sv */
// pin level link between local master and bridge slave
`timescale 1ns/1ps
interface lbs_link_if;
  logic transfer_start_n;
  logic [31:0] addr;
  logic rw;
  logic pci_window_select_n;
  logic register_window_select_n;
  logic image_choice;
  logic transfer_ack_n_o;
  logic transfer_ack_n_oe;
  logic transfer_error_n_o;
  logic transfer_error_n_oe;
  logic transfer_in_progress_n_o;
  logic transfer_in_progress_n_oe;
  logic irq_dev_oe;
  logic irq_host_oe;
  logic local_irq_n;
  logic local_reset_in_n;
  logic reset_out_oe;
  logic local_reset_out_n;
  logic transfer_ack_n;
  logic transfer_error_n;
  // resolved wire levels: open drain lines are pulled up
  assign local_irq_n = ~(irq_dev_oe | irq_host_oe);
  assign local_reset_out_n = ~reset_out_oe;
  assign transfer_ack_n = transfer_ack_n_oe ? transfer_ack_n_o : 1'b1;
  assign transfer_error_n = transfer_error_n_oe ? transfer_error_n_o : 1'b1;
  modport device_end (
    input transfer_start_n, addr, rw, pci_window_select_n, register_window_select_n,
    input image_choice, local_irq_n, local_reset_in_n,
    output transfer_ack_n_o, transfer_ack_n_oe, transfer_error_n_o, transfer_error_n_oe,
    output transfer_in_progress_n_o, transfer_in_progress_n_oe, irq_dev_oe, reset_out_oe
  );
  modport host_end (
    output transfer_start_n, addr, rw, pci_window_select_n, register_window_select_n,
    output image_choice, irq_host_oe, local_reset_in_n,
    input transfer_ack_n, transfer_error_n, local_irq_n, local_reset_out_n
  );
endinterface : lbs_link_if

/* hw/lbs_irq_route.sv */
// open drain interrupt pin routing in both directions
`timescale 1ns/1ps
module lbs_irq_route
  import lbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic irq_event,
  input wire logic irq_in_enable,
  input wire logic local_irq_n,
  output logic irq_pin_oe,
  output logic pci_inta_n
);
  logic inta_reg;
  logic inta_next;
  assign irq_pin_oe = irq_event;
  always_comb
  begin
    // our own pull is excluded so the pin cannot latch itself onto inta
    inta_next = irq_in_enable & ~local_irq_n & ~irq_event;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      inta_reg <= 1'b0;
    else
      inta_reg <= inta_next;
  end
  assign pci_inta_n = ~inta_reg;
endmodule : lbs_irq_route

/* hw/lbs_host.sv */
// local master end: starts cycles and reads termination
`timescale 1ns/1ps
`include "lbs_cfg.svh"
module lbs_host
  import lbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  lbs_link_if.host_end link,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_addr,
  input wire logic cmd_rw,
  input wire lbs_target_t cmd_target,
  input wire logic cmd_image,
  input wire logic cmd_none,
  input wire logic [1:0] cmd_sel_wait,
  input wire logic irq_assert,
  input wire logic local_reset_req,
  output logic cmd_ready,
  output logic done_valid,
  output lbs_term_t done_kind,
  output logic irq_seen,
  output logic bridge_reset_seen
);
  typedef enum logic [1:0] {LBH_IDLE, LBH_START, LBH_WAIT} lbh_state_t;
  lbh_state_t state_reg, state_next;
  logic [31:0] addr_reg, addr_next;
  logic rw_reg, rw_next;
  logic tgt_reg, tgt_next;
  logic img_reg, img_next;
  logic none_reg, none_next;
  logic done_reg, done_next;
  lbs_term_t kind_reg, kind_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [1:0] dly_reg, dly_next;
  logic ack, err;
  assign ack = ~link.transfer_ack_n;
  assign err = ~link.transfer_error_n;
  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    tgt_next = tgt_reg;
    img_next = img_reg;
    none_next = none_reg;
    done_next = 1'b0;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    dly_next = dly_reg;
    unique case (state_reg)
      LBH_IDLE:
      begin
        if (cmd_valid)
        begin
          addr_next = cmd_addr;
          rw_next = cmd_rw;
          tgt_next = cmd_target;
          img_next = cmd_image;
          none_next = cmd_none;
          dly_next = cmd_sel_wait;
          state_next = LBH_START;
        end
      end
      LBH_START:
      begin
        cnt_next = 3'h0;
        state_next = LBH_WAIT;
      end
      LBH_WAIT:
      begin
        // saturate so a late select stays asserted during a long wait
        cnt_next = (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
        if (ack | err)
        begin
          done_next = 1'b1;
          kind_next = (ack & err) ? LBS_TERM_RETRY
            : (ack ? LBS_TERM_ACK : LBS_TERM_ERROR);
          state_next = LBH_IDLE;
        end
        else if (none_reg && cnt_reg == 3'(`LBS_CS_WAIT_MAX + 1))
        begin
          // unclaimed cycle: report an error locally as a bus timeout would
          done_next = 1'b1;
          kind_next = LBS_TERM_ERROR;
          state_next = LBH_IDLE;
        end
      end
      default:
        state_next = LBH_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= LBH_IDLE;
      dly_reg <= 2'h0;
      addr_reg <= 32'h0;
      rw_reg <= 1'b0;
      tgt_reg <= 1'b0;
      img_reg <= 1'b0;
      none_reg <= 1'b0;
      done_reg <= 1'b0;
      kind_reg <= LBS_TERM_ACK;
      cnt_reg <= 3'h0;
    end
    else
    begin
      state_reg <= state_next;
      dly_reg <= dly_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      tgt_reg <= tgt_next;
      img_reg <= img_next;
      none_reg <= none_next;
      done_reg <= done_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
    end
  end
  logic in_cycle;
  logic sel_due;
  // selects may trail the start by up to three wait states
  assign sel_due = (state_reg == LBH_START) ? (dly_reg == 2'h0)
    : (({1'b0, cnt_reg} + 4'h1) >= {2'h0, dly_reg});
  assign in_cycle = (state_reg != LBH_IDLE) & ~none_reg & sel_due;
  assign cmd_ready = (state_reg == LBH_IDLE);
  assign link.transfer_start_n = ~(state_reg == LBH_START);
  assign link.addr = addr_reg;
  assign link.rw = rw_reg;
  assign link.image_choice = img_reg;
  assign link.pci_window_select_n = ~(in_cycle & (tgt_reg == LBS_TGT_PCI));
  assign link.register_window_select_n = ~(in_cycle & (tgt_reg == LBS_TGT_REG));
  assign link.irq_host_oe = irq_assert;
  assign link.local_reset_in_n = ~local_reset_req;
  assign done_valid = done_reg;
  assign done_kind = kind_reg;
  assign irq_seen = ~link.local_irq_n;
  assign bridge_reset_seen = ~link.local_reset_out_n;
endmodule : lbs_host

/* verif/lbs_link_asserts.sv */
// concurrent checks on the pins between local master and bridge slave
`timescale 1ns/1ps
module lbs_link_asserts
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic transfer_start_n,
  input wire logic pci_window_select_n,
  input wire logic register_window_select_n,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_n_oe,
  input wire logic transfer_error_n_o,
  input wire logic transfer_error_n_oe,
  input wire logic local_reset_in_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic any_sel;
  logic any_oe;
  assign any_sel = !(pci_window_select_n && register_window_select_n);
  assign any_oe = transfer_ack_n_oe || transfer_error_n_oe;
  // ----------------------------------------
  // termination shape
  // ----------------------------------------
  a_ack_one_cycle: assert property (
    transfer_ack_n_oe && !transfer_ack_n_o |=>
    transfer_ack_n_oe && transfer_ack_n_o ##1 !transfer_ack_n_oe)
    else $error("acknowledge not asserted, negated, then released");
  a_err_one_cycle: assert property (
    transfer_error_n_oe && !transfer_error_n_o |=>
    transfer_error_n_oe && transfer_error_n_o ##1 !transfer_error_n_oe)
    else $error("error not asserted, negated, then released");
  a_first_drive_low: assert property (
    $rose(any_oe) |-> (transfer_ack_n_oe && !transfer_ack_n_o) ||
    (transfer_error_n_oe && !transfer_error_n_o))
    else $error("termination first driven at negated level");
  a_ack_gap_after: assert property (
    $fell(transfer_ack_n_oe) |-> !transfer_ack_n_oe [*2])
    else $error("acknowledge driven again right after release");
  a_err_gap_after: assert property (
    $fell(transfer_error_n_oe) |-> !transfer_error_n_oe [*2])
    else $error("error driven again right after release");
  // ----------------------------------------
  // cycle start, selection and local reset
  // ----------------------------------------
  // a cycle with no select inside the window must stay silent
  a_unsel_silent: assert property (
    (!transfer_start_n && !any_sel) ##1 !any_sel [*3] |=> !any_oe [*4])
    else $error("unselected cycle was terminated");
  a_no_early_term: assert property (
    !transfer_start_n && any_sel |=> !any_oe)
    else $error("termination in the cycle after start");
  a_local_reset_quiet: assert property (
    !local_reset_in_n |=> !any_oe)
    else $error("termination driven during local reset");
endmodule : lbs_link_asserts

/* verif/local_bus_slave_signalling_tb.sv */
// self-checking bench joining the master end and the bridge end
`timescale 1ns/1ps
module local_bus_slave_signalling_tb
  import lbs_pkg::*;
;
  typedef struct {lbs_target_t tgt; logic img; logic rw; logic [31:0] adr;
    lbs_term_t k; logic [1:0] pins; logic [1:0] dly;} lbs_row_t;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic master_active = 1'h0, pci_reset_in = 1'h0, soft_reset_bit = 1'h0;
  logic irq_event = 1'h0, irq_in_enable = 1'h0, resp_valid = 1'h0;
  lbs_term_t resp_kind = LBS_TERM_ACK;
  logic req_valid, req_rw, req_image, local_side_reset, pci_inta_n;
  lbs_target_t req_target;
  logic [31:0] req_addr;
  logic [11:0] req_reg_offset;
  logic cmd_valid = 1'h0, cmd_rw = 1'h0, cmd_image = 1'h0, cmd_none = 1'h0;
  logic [31:0] cmd_addr = 32'h0;
  logic [1:0] cmd_sel_wait = 2'h0;
  lbs_target_t cmd_target = LBS_TGT_PCI;
  logic irq_assert = 1'h0, local_reset_req = 1'h0;
  logic cmd_ready, done_valid, irq_seen, bridge_reset_seen;
  lbs_term_t done_kind;
  int bad_count = 0;
  int n_checks = 0;
  // expected pins are {ack, error} on the resolved wires; dly is select lag
  lbs_row_t rows [4] = '{
    '{LBS_TGT_PCI, 1'h0, 1'h1, 32'h1000_0004, LBS_TERM_ACK, 2'h1, 2'h0},
    '{LBS_TGT_REG, 1'h1, 1'h0, 32'hABCD_EFFC, LBS_TERM_RETRY, 2'h0, 2'h3},
    '{LBS_TGT_PCI, 1'h1, 1'h0, 32'h8765_4000, LBS_TERM_ERROR, 2'h2, 2'h1},
    '{LBS_TGT_REG, 1'h0, 1'h1, 32'h0000_0123, LBS_TERM_ACK, 2'h1, 2'h2}};
  lbs_link_if u_lbs_link_if ();
  lbs_device u_lbs_device (.clk_sys(clk_sys), .reset(reset), .link(u_lbs_link_if.device_end),
    .master_active(master_active), .pci_reset_in(pci_reset_in),
    .soft_reset_bit(soft_reset_bit), .irq_event(irq_event), .irq_in_enable(irq_in_enable),
    .resp_valid(resp_valid), .resp_kind(resp_kind), .req_valid(req_valid),
    .req_target(req_target), .req_addr(req_addr), .req_reg_offset(req_reg_offset),
    .req_rw(req_rw), .req_image(req_image), .local_side_reset(local_side_reset),
    .pci_inta_n(pci_inta_n));
  lbs_host u_lbs_host (.clk_sys(clk_sys), .reset(reset), .link(u_lbs_link_if.host_end),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_rw(cmd_rw), .cmd_target(cmd_target),
    .cmd_image(cmd_image), .cmd_none(cmd_none), .cmd_sel_wait(cmd_sel_wait),
    .irq_assert(irq_assert),
    .local_reset_req(local_reset_req), .cmd_ready(cmd_ready), .done_valid(done_valid),
    .done_kind(done_kind), .irq_seen(irq_seen), .bridge_reset_seen(bridge_reset_seen));
  lbs_link_asserts u_lbs_link_asserts (.clk_sys(clk_sys), .reset(reset),
    .transfer_start_n(u_lbs_link_if.transfer_start_n),
    .pci_window_select_n(u_lbs_link_if.pci_window_select_n),
    .register_window_select_n(u_lbs_link_if.register_window_select_n),
    .transfer_ack_n_o(u_lbs_link_if.transfer_ack_n_o),
    .transfer_ack_n_oe(u_lbs_link_if.transfer_ack_n_oe),
    .transfer_error_n_o(u_lbs_link_if.transfer_error_n_o),
    .transfer_error_n_oe(u_lbs_link_if.transfer_error_n_oe),
    .local_reset_in_n(u_lbs_link_if.local_reset_in_n));
  always #5 clk_sys = ~clk_sys;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic run_cmd(input lbs_row_t r, input logic none);
    int n;
    logic seen_req;
    n = 0;
    seen_req = 1'h0;
    while (cmd_ready !== 1'h1 && n < 50)
    begin
      tick(1);
      n++;
    end
    {cmd_valid, cmd_none, cmd_image, cmd_rw} = {1'h1, none, r.img, r.rw};
    cmd_target = r.tgt;
    cmd_sel_wait = r.dly;
    cmd_addr = r.adr;
    tick(1);
    cmd_valid = 1'h0;
    n = 0;
    // a pending request is answered here; the done pulse is watched below
    while (done_valid !== 1'h1 && n < 60)
    begin
      if (req_valid === 1'h1)
      begin
        seen_req = 1'h1;
        chk(n, 1 + r.dly);
        chk(req_target, r.tgt);
        chk(req_addr, r.adr);
        chk(req_reg_offset, r.adr[11:0]);
        chk(req_image, r.img);
        chk(req_rw, r.rw);
        tick(1);
        resp_valid = 1'h1;
        resp_kind = r.k;
        tick(1);
        resp_valid = 1'h0;
        chk({u_lbs_link_if.transfer_ack_n, u_lbs_link_if.transfer_error_n}, r.pins);
      end
      tick(1);
      n++;
    end
    chk(done_valid, 1'h1);
    chk(done_kind, none ? LBS_TERM_ERROR : r.k);
    chk(seen_req, !none);
  endtask : run_cmd
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    tick(16);
    reset = 1'h0;
    chk(u_lbs_link_if.transfer_ack_n_oe, 1'h0);
    chk(u_lbs_link_if.local_reset_out_n, 1'h1);
    foreach (rows[i])
    begin
      run_cmd(rows[i], 1'h0);
      $display("row %0d done", i);
    end
    run_cmd(rows[0], 1'h1);
    $display("unselected cycle done");
    for (int i = 1; i < 4; i++)
    begin
      {pci_reset_in, soft_reset_bit} = i[1:0];
      tick(1);
      chk(u_lbs_link_if.local_reset_out_n, 1'h0);
      chk(bridge_reset_seen, 1'h1);
    end
    {pci_reset_in, soft_reset_bit} = 2'h0;
    irq_event = 1'h1;
    tick(1);
    chk({u_lbs_link_if.local_irq_n, irq_seen}, 2'h1);
    irq_event = 1'h0;
    irq_assert = 1'h1;
    tick(3);
    chk(pci_inta_n, 1'h1);
    irq_in_enable = 1'h1;
    tick(3);
    chk(pci_inta_n, 1'h0);
    irq_assert = 1'h0;
    tick(3);
    chk(pci_inta_n, 1'h1);
    $display("reset out and interrupt done");
    master_active = 1'h1;
    tick(2);
    chk(u_lbs_link_if.transfer_in_progress_n_oe, 1'h1);
    chk(u_lbs_link_if.transfer_in_progress_n_o, 1'h0);
    master_active = 1'h0;
    local_reset_req = 1'h1;
    tick(3);
    chk(local_side_reset, 1'h1);
    local_reset_req = 1'h0;
    tick(3);
    chk(local_side_reset, 1'h0);
    chk(u_lbs_link_if.transfer_in_progress_n_oe, 1'h0);
    run_cmd(rows[1], 1'h0);
    $display("tip and local reset done");
    finish_test();
  end
  initial
  begin
    #100000;
    bad_count++;
    finish_test();
  end
endmodule : local_bus_slave_signalling_tb
